// ===== common/autozero_fb_pkg.sv
// Constants shared by the offset-calibration and measurement-readback register logic.
// Assumes a 32-bit serial frame and two load channels.
`default_nettype none

package autozero_fb_pkg;

   // Frame layout.
   localparam int FRAME_BITS = 32;
   localparam int LAST_BIT   = 31;
   localparam int CNT_W      = 6;
   localparam int DIR_BIT    = 31;
   localparam int CODE_MSB   = 30;
   localparam int CODE_LSB   = 27;
   localparam int CODE_W     = 4;
   localparam int CHAN_MSB   = 25;
   localparam int CHAN_LSB   = 24;
   localparam int DATA_W     = 24;

   // Register codes and channel codes.
   localparam logic [CODE_W-1:0] CODE_OFFSET_CAL = 4'h7;
   localparam logic [CODE_W-1:0] CODE_READBACK   = 4'h8;
   localparam logic [1:0]        CHAN_FIRST      = 2'h1;
   localparam logic [1:0]        CHAN_SECOND     = 2'h2;

   // Offset calibration register fields.
   localparam int   LAUNCH_BIT   = 23;
   localparam logic LAUNCH_RESET = 1'b1;
   localparam int   OFFSET_W     = 13;

   // Measurement readback fields.
   localparam int SAMPLE_W   = 16;
   localparam int CAL_LSB    = 8;
   localparam int CAL_W      = 16;
   localparam int SUM_LSB    = 12;
   localparam int SUM_W      = 12;
   localparam int PERIOD_LSB = 0;
   localparam int PERIOD_W   = 12;
   localparam int MAX_LSB    = 16;
   localparam int MIN_LSB    = 8;
   localparam int CYC_LSB    = 0;
   localparam int EXT_W      = 8;

   localparam logic [EXT_W-1:0] MAX_CLEAR = 8'h00;
   localparam logic [EXT_W-1:0] MIN_CLEAR = 8'hFF;

   // One period step is this many system clocks.
   localparam int             PERIOD_PRESCALE = 16;
   localparam int             PRESC_W         = 4;
   localparam logic [PRESC_W-1:0] PRESC_LAST  = 4'hF;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_CAPTURE = 3'b010,
      ST_ACT     = 3'b100
   } frame_state_type;

endpackage : autozero_fb_pkg

`default_nettype wire

// ===== core/bit_sync.sv
// Two-flop synchroniser for a single level.
// Assumes the destination clock and a synchronous active-low reset.
`default_nettype none

module bit_sync #(
   parameter logic RESET_VALUE = 1'b0
) (
   // Destination domain.
   input  wire logic clock_i,
   input  wire logic resetn_i,
   // Level from another domain.
   input  wire logic async_i,
   output logic      sync_o
);

   logic meta;

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         meta   <= RESET_VALUE;
         sync_o <= RESET_VALUE;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

endmodule : bit_sync

`default_nettype wire

// ===== core/channel_meas.sv
// Per-channel measurement tracker: cycle current sum, period, extremes, cycles per dither.
// Assumes samples, cycle ends and dither ends arrive as pulses on the system clock.
`default_nettype none

module channel_meas
   import autozero_fb_pkg::*;
(
   // Clock and reset.
   input  wire logic                clock_i,
   input  wire logic                resetn_i,
   // Channel state and measurement events.
   input  wire logic                active_i,
   input  wire logic                dither_en_i,
   input  wire logic                sample_valid_i,
   input  wire logic [SAMPLE_W-1:0] sample_i,
   input  wire logic                cycle_end_i,
   input  wire logic                dither_end_i,
   // Read side effects.
   input  wire logic                clear_cycle_i,
   input  wire logic                clear_extreme_i,
   // Reported values.
   output logic [CAL_W-1:0]         cal_current_o,
   output logic [SUM_W-1:0]         cycle_sum_o,
   output logic [PERIOD_W-1:0]      period_o,
   output logic [EXT_W-1:0]         max_o,
   output logic [EXT_W-1:0]         min_o,
   output logic [EXT_W-1:0]         cycles_o
);

   logic                run;
   logic [EXT_W-1:0]    step;
   logic [SUM_W:0]      sum_add;
   logic [SUM_W-1:0]    sum_run;
   logic [PRESC_W-1:0]  presc;
   logic [PERIOD_W-1:0] period_run;
   logic [EXT_W-1:0]    run_max;
   logic [EXT_W-1:0]    run_min;
   logic [EXT_W-1:0]    run_cnt;
   logic [EXT_W-1:0]    next_run_max;
   logic [EXT_W-1:0]    next_run_min;
   logic [EXT_W-1:0]    next_run_cnt;

   assign run     = resetn_i && active_i;
   assign step    = sample_i[SAMPLE_W-1 -: EXT_W];
   assign sum_add = {1'b0, sum_run} + {{(SUM_W + 1 - EXT_W){1'b0}}, step};

   assign next_run_max = (sample_valid_i && step > run_max) ? step : run_max;
   assign next_run_min = (sample_valid_i && step < run_min) ? step : run_min;
   assign next_run_cnt = (cycle_end_i && run_cnt != MIN_CLEAR) ? run_cnt + 1'b1 : run_cnt;

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         cal_current_o <= '0;
      end else if (sample_valid_i) begin
         cal_current_o <= sample_i;
      end
   end

   // Current summed over the running switching cycle, saturating.
   always_ff @(posedge clock_i) begin
      if (!run || cycle_end_i) begin
         sum_run <= '0;
      end else if (sample_valid_i) begin
         sum_run <= sum_add[SUM_W] ? '1 : sum_add[SUM_W-1:0];
      end
   end

   // A new cycle result wins over a read clear in the same cycle.
   always_ff @(posedge clock_i) begin
      if (!run) begin
         cycle_sum_o <= '0;
      end else if (cycle_end_i) begin
         cycle_sum_o <= sum_run;
      end else if (clear_cycle_i) begin
         cycle_sum_o <= '0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!run || cycle_end_i) begin
         presc <= '0;
      end else begin
         presc <= presc + 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!run || cycle_end_i) begin
         period_run <= '0;
      end else if (presc == PRESC_LAST && period_run != '1) begin
         period_run <= period_run + 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!run) begin
         period_o <= '0;
      end else if (cycle_end_i && presc == PRESC_LAST && period_run != '1) begin
         period_o <= period_run + 1'b1;
      end else if (cycle_end_i) begin
         period_o <= period_run;
      end
   end

   // Running extremes and cycle count over the current dither cycle.
   always_ff @(posedge clock_i) begin
      if (!run || !dither_en_i || dither_end_i) begin
         run_max <= MAX_CLEAR;
         run_min <= MIN_CLEAR;
         run_cnt <= '0;
      end else begin
         run_max <= next_run_max;
         run_min <= next_run_min;
         run_cnt <= next_run_cnt;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!run) begin
         max_o <= MAX_CLEAR;
         min_o <= MIN_CLEAR;
      end else if (dither_en_i) begin
         if (dither_end_i) begin
            max_o <= next_run_max;
            min_o <= next_run_min;
         end else if (clear_extreme_i) begin
            max_o <= MAX_CLEAR;
            min_o <= MIN_CLEAR;
         end
      end else begin
         if (sample_valid_i && (clear_extreme_i || step > max_o)) begin
            max_o <= step;
         end else if (clear_extreme_i) begin
            max_o <= MAX_CLEAR;
         end
         if (sample_valid_i && (clear_extreme_i || step < min_o)) begin
            min_o <= step;
         end else if (clear_extreme_i) begin
            min_o <= MIN_CLEAR;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!run || !dither_en_i) begin
         cycles_o <= '0;
      end else if (dither_end_i) begin
         cycles_o <= next_run_cnt;
      end else if (clear_extreme_i) begin
         cycles_o <= '0;
      end
   end

endmodule : channel_meas

`default_nettype wire

// ===== core/autozero_feedback_regs.sv
// Serial-accessed offset calibration and measurement readback registers for two load channels.
// Assumes an external master sends 32-bit frames on its own link clock, sampled on the rising edge,
// and that measurement events come from logic on the system clock.
`default_nettype none

module autozero_feedback_regs
   import autozero_fb_pkg::*;
(
   // System clock and reset.
   input  wire logic                          clock_i,
   input  wire logic                          resetn_i,
   // Serial link, on its own clock.
   input  wire logic                          link_clk_i,
   input  wire logic                          frame_sel_n_i,
   input  wire logic                          link_data_i,
   output logic                               link_data_o,
   output logic                               link_data_oe_o,
   // Operating modes from the rest of the device.
   input  wire logic                          cal_mode_i,
   input  wire logic                          feedback_layout_select_i,
   input  wire logic [1:0]                    output_enable_i,
   input  wire logic [1:0]                    channel_active_i,
   input  wire logic [1:0]                    dither_enable_i,
   // Measurement events per channel.
   input  wire logic [1:0]                    sample_valid_i,
   input  wire logic [1:0][SAMPLE_W-1:0]      sample_i,
   input  wire logic [1:0]                    cycle_end_i,
   input  wire logic [1:0]                    dither_end_i,
   // Offset calibration sequencer per channel.
   output logic [1:0]                         offset_cal_launch_o,
   input  wire logic [1:0]                    offset_cal_done_i,
   input  wire logic [1:0][OFFSET_W-1:0]      offset_cal_value_i
);

   // Link domain.
   logic [CNT_W-1:0]      bit_cnt;
   logic [LAST_BIT-1:0]   rx_shift;
   logic [FRAME_BITS-1:0] frame_word;
   logic [4:0]            out_idx;

   // System domain.
   logic                      frame_full;
   logic                      frame_full_d;
   frame_state_type           state;
   frame_state_type           next_state;
   // Captured frame and reply words.
   logic [FRAME_BITS-1:0]     cmd;
   logic [FRAME_BITS-1:0]     reply_word;
   logic [FRAME_BITS-1:0]     next_reply;

   // Launch control and read side effects.
   logic                      launch_bit;
   logic                      next_launch_bit;
   logic [1:0]                next_launch;
   logic [1:0]                clear_cycle;
   logic [1:0]                clear_extreme;
   logic [1:0][OFFSET_W-1:0]  offset_result;

   // Frame decode.
   logic [CODE_W-1:0]         cmd_code;
   logic [1:0]                cmd_chan;
   logic                      chan_ok;
   logic                      ch;
   logic [DATA_W-1:0]         fb_data;

   // Tracker outputs per channel.
   logic [1:0][CAL_W-1:0]     cal_current;
   logic [1:0][SUM_W-1:0]     cycle_sum;
   logic [1:0][PERIOD_W-1:0]  period;
   logic [1:0][EXT_W-1:0]     max_cur;
   logic [1:0][EXT_W-1:0]     min_cur;
   logic [1:0][EXT_W-1:0]     cycles;

   // The bit counter restarts whenever the select pin goes high, so a partial frame is dropped.
   always_ff @(posedge link_clk_i or posedge frame_sel_n_i) begin
      if (frame_sel_n_i) begin
         bit_cnt <= '0;
      end else if (bit_cnt != CNT_W'(FRAME_BITS)) begin
         bit_cnt <= bit_cnt + 1'b1;
      end
   end

   // Incoming bits, first bit leftmost.
   always_ff @(posedge link_clk_i) begin
      rx_shift <= {rx_shift[LAST_BIT-2:0], link_data_i};
   end

   // The captured word stays still until the next full frame, long after the system side took it.
   always_ff @(posedge link_clk_i) begin
      if (bit_cnt == CNT_W'(LAST_BIT)) begin
         frame_word <= {rx_shift, link_data_i};
      end
   end

   // Reply bit driven after this falling edge.
   assign out_idx = 5'(LAST_BIT) - bit_cnt[4:0];

   // The reply is held stable by the system side for the whole frame; the first bit is the
   // direction bit, which always reads zero.
   always_ff @(negedge link_clk_i or posedge frame_sel_n_i) begin
      if (frame_sel_n_i) begin
         link_data_o <= 1'b0;
      end else if (bit_cnt < CNT_W'(FRAME_BITS)) begin
         link_data_o <= reply_word[out_idx];
      end
   end

   // The reply pin is driven while the frame is selected.
   assign link_data_oe_o = !frame_sel_n_i;

   // The top counter bit alone marks a full frame, so no decode glitch can cross.
   bit_sync #(
      .RESET_VALUE (1'b0)
   ) u_frame_sync (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .async_i  (bit_cnt[CNT_W-1]),
      .sync_o   (frame_full)
   );

   // Delayed flag, so that each frame is taken once.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         frame_full_d <= 1'b0;
      end else begin
         frame_full_d <= frame_full;
      end
   end

   // Take the frame word once, then act on it.
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (frame_full && !frame_full_d) begin
               next_state = ST_CAPTURE;
            end
         end
         ST_CAPTURE: begin
            next_state = ST_ACT;
         end
         ST_ACT: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // The frame word is still by the time it is taken here.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         cmd <= '0;
      end else if (state == ST_CAPTURE) begin
         cmd <= frame_word;
      end
   end

   // Bit 26 of the frame is never looked at.
   assign cmd_code = cmd[CODE_MSB:CODE_LSB];
   assign cmd_chan = cmd[CHAN_MSB:CHAN_LSB];
   assign chan_ok  = (cmd_chan == CHAN_FIRST) || (cmd_chan == CHAN_SECOND);
   assign ch       = (cmd_chan == CHAN_SECOND);

   // Frame actions and the reply for the next frame.
   always_comb begin
      next_reply      = reply_word;
      next_launch_bit = launch_bit;
      next_launch     = '0;
      clear_cycle     = '0;
      clear_extreme   = '0;
      fb_data         = '0;
      if (state == ST_ACT) begin
         next_reply = '0;
         if (cmd_code == CODE_OFFSET_CAL) begin
            // Writes store the launch bit for every channel.
            if (cmd[DIR_BIT]) begin
               next_launch_bit = cmd[LAUNCH_BIT];
               if (cmd[LAUNCH_BIT] && chan_ok && !output_enable_i[ch]) begin
                  next_launch[ch] = 1'b1;
               end
            end
            next_reply[CODE_MSB:CODE_LSB] = CODE_OFFSET_CAL;
            next_reply[CHAN_MSB:CHAN_LSB] = cmd_chan;
            next_reply[LAUNCH_BIT]        = next_launch_bit;
            if (chan_ok) begin
               next_reply[OFFSET_W-1:0] = offset_result[ch];
            end
         end else if (cmd_code == CODE_READBACK) begin
            // The direction bit is not looked at here, so a write acts as a read.
            if (chan_ok) begin
               if (cal_mode_i) begin
                  fb_data[CAL_LSB +: CAL_W] = cal_current[ch];
               end else if (!feedback_layout_select_i) begin
                  fb_data[SUM_LSB +: SUM_W]       = cycle_sum[ch];
                  fb_data[PERIOD_LSB +: PERIOD_W] = period[ch];
                  clear_cycle[ch]                 = 1'b1;
               end else begin
                  fb_data[MAX_LSB +: EXT_W] = max_cur[ch];
                  fb_data[MIN_LSB +: EXT_W] = min_cur[ch];
                  fb_data[CYC_LSB +: EXT_W] = cycles[ch];
                  clear_extreme[ch]         = 1'b1;
               end
               // Idle channels report zeros outside calibration mode.
               if (!channel_active_i[ch] && !cal_mode_i) begin
                  fb_data = '0;
               end
            end
            next_reply[CODE_MSB:CODE_LSB] = CODE_READBACK;
            next_reply[CHAN_MSB:CHAN_LSB] = cmd_chan;
            next_reply[DATA_W-1:0]        = fb_data;
         end
      end
   end

   // Only changes between frames, so the link side reads it safely.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         reply_word <= '0;
      end else begin
         reply_word <= next_reply;
      end
   end

   // One launch bit is shared by both channels.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         launch_bit <= LAUNCH_RESET;
      end else begin
         launch_bit <= next_launch_bit;
      end
   end

   // One-cycle pulse to the calibration sequencer.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         offset_cal_launch_o <= '0;
      end else begin
         offset_cal_launch_o <= next_launch;
      end
   end

   // Each channel keeps its last measured offset.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         offset_result <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (offset_cal_done_i[i]) begin
               offset_result[i] <= offset_cal_value_i[i];
            end
         end
      end
   end

   // One measurement tracker per load channel.
   for (genvar g = 0; g < 2; g++) begin : g_chan
      channel_meas u_meas (
         .clock_i         (clock_i),
         .resetn_i        (resetn_i),
         .active_i        (channel_active_i[g]),
         .dither_en_i     (dither_enable_i[g]),
         .sample_valid_i  (sample_valid_i[g]),
         .sample_i        (sample_i[g]),
         .cycle_end_i     (cycle_end_i[g]),
         .dither_end_i    (dither_end_i[g]),
         .clear_cycle_i   (clear_cycle[g]),
         .clear_extreme_i (clear_extreme[g]),
         .cal_current_o   (cal_current[g]),
         .cycle_sum_o     (cycle_sum[g]),
         .period_o        (period[g]),
         .max_o           (max_cur[g]),
         .min_o           (min_cur[g]),
         .cycles_o        (cycles[g])
      );
   end

endmodule : autozero_feedback_regs

`default_nettype wire

// ===== bench/autozero_fb_assertions.sv
// Port-level checks for the offset calibration and readback register block.
// Assumes it is bound into the register block and sees only its top-level ports.
`default_nettype none

module autozero_fb_checker (
   // System side.
   input wire logic       clock_i,
   input wire logic       resetn_i,
   // Link pins.
   input wire logic       link_clk_i,
   input wire logic       frame_sel_n_i,
   input wire logic       link_data_o,
   input wire logic       link_data_oe_o,
   // Calibration control.
   input wire logic [1:0] output_enable_i,
   input wire logic [1:0] offset_cal_launch_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic bit_seen;

   // The link side has no reset, so frame select marks the first bit of each frame.
   always_ff @(posedge link_clk_i or posedge frame_sel_n_i) begin
      if (frame_sel_n_i) begin
         bit_seen <= 1'h0;
      end else begin
         bit_seen <= 1'h1;
      end
   end

   sequence s_launch;
      offset_cal_launch_o != 2'h0;
   endsequence

   sequence s_link_idle;
      frame_sel_n_i [*3];
   endsequence

   property p_oe_select;
      @(posedge clock_i) disable iff (!resetn_i) link_data_oe_o == !frame_sel_n_i;
   endproperty
   a_oe_select: assert property (p_oe_select) else $error("enable differs from select");

   property p_idle_low;
      @(posedge clock_i) disable iff (!resetn_i) s_link_idle |-> !link_data_o;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("reply line busy between frames");

   property p_first_bit;
      @(posedge link_clk_i) disable iff (frame_sel_n_i) !bit_seen |-> !link_data_o;
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("direction bit of reply not zero");

   property p_quiet_change;
      @(posedge clock_i) disable iff (!resetn_i)
         $changed(link_data_o) |-> !(frame_sel_n_i && $past(frame_sel_n_i));
   endproperty
   a_quiet_change: assert property (p_quiet_change) else $error("reply moved outside a frame");

   property p_pulse;
      @(posedge clock_i) disable iff (!resetn_i) s_launch |=> (offset_cal_launch_o == 2'h0) [*8];
   endproperty
   a_pulse: assert property (p_pulse) else $error("launch longer than one cycle");

   property p_one_chan;
      @(posedge clock_i) disable iff (!resetn_i) s_launch |-> $onehot(offset_cal_launch_o);
   endproperty
   a_one_chan: assert property (p_one_chan) else $error("launch on both channels");

   property p_after_frame;
      @(posedge clock_i) disable iff (!resetn_i) s_launch |-> $past(frame_sel_n_i, 8) == 1'h0;
   endproperty
   a_after_frame: assert property (p_after_frame) else $error("launch without a frame");

   property p_refused;
      @(posedge clock_i) disable iff (!resetn_i) s_launch |-> (offset_cal_launch_o & output_enable_i) == 2'h0;
   endproperty
   a_refused: assert property (p_refused) else $error("launch while output enabled");
endmodule : autozero_fb_checker

bind autozero_feedback_regs autozero_fb_checker i_autozero_fb_checker (
   .clock_i            (clock_i),
   .resetn_i           (resetn_i),
   .link_clk_i         (link_clk_i),
   .frame_sel_n_i      (frame_sel_n_i),
   .link_data_o        (link_data_o),
   .link_data_oe_o     (link_data_oe_o),
   .output_enable_i    (output_enable_i),
   .offset_cal_launch_o(offset_cal_launch_o)
);

`default_nettype wire

// ===== bench/link_master_model.sv
// Behavioural serial master that sends 32-bit frames and collects the replies.
// Assumes the device samples on the rising link edge and shifts out on the falling one.
`default_nettype none

module link_master_model (
   // Link pins.
   output logic      link_clk_o,
   output logic      frame_sel_n_o,
   output logic      tx_data_o,
   input  wire logic rx_data_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // A rising select after time zero resets the device's link logic.
   initial begin
      link_clk_o = 1'h0;
      frame_sel_n_o = 1'h0;
      tx_data_o = 1'h0;
      #10;
      frame_sel_n_o = 1'h1;
   end

   // The clock stands still between frames and the released data line shows the inverse.
   task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
      #37;
      frame_sel_n_o = 1'h0;
      for (int i = 31; i >= 0; i--) begin
         tx_data_o = tx[i];
         #80;
         link_clk_o = 1'h1;
         rx[i] = rx_data_i;
         #80;
         link_clk_o = 1'h0;
      end
      #400;
      frame_sel_n_o = 1'h1;
      tx_data_o = ~tx_data_o;
      #1200;
   endtask : xfer
endmodule : link_master_model

`default_nettype wire

// ===== bench/test_autozero_feedback_regs.sv
// Self-checking bench for the offset calibration and readback registers.
// Assumes the link master model and the bound port checker.
`default_nettype none

module test_autozero_feedback_regs import autozero_fb_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic                     clock_i  = 1'h0;
   logic                     resetn_i = 1'h0;
   logic                     cal_mode = 1'h0;
   logic                     fb_sel   = 1'h0;
   logic [1:0]               out_en   = 2'h2;
   logic [1:0]               active   = 2'h0;
   logic [1:0]               dither   = 2'h0;
   logic [1:0]               valid    = 2'h0;
   logic [1:0]               cyc_end  = 2'h0;
   logic [1:0]               dth_end  = 2'h0;
   logic [1:0]               done     = 2'h0;
   logic [1:0][SAMPLE_W-1:0] sample   = '0;
   logic [1:0][OFFSET_W-1:0] offset   = '0;
   logic [1:0]               launch;
   wire logic                link_clk;
   wire logic                frame_sel_n;
   wire logic                mosi;
   wire logic                miso;
   int                       error_cnt = 0;
   int                       tests_run = 0;
   int                       nl [2]    = '{0, 0};

   always #50 clock_i = ~clock_i;

   always @(posedge clock_i) begin
      for (int c = 0; c < 2; c++) begin
         if (launch[c] === 1'h1) begin
            nl[c]++;
         end
      end
   end

   autozero_feedback_regs i_autozero_feedback_regs (
      .clock_i(clock_i), .resetn_i(resetn_i), .link_clk_i(link_clk), .frame_sel_n_i(frame_sel_n),
      .link_data_i(mosi), .link_data_o(miso), .link_data_oe_o(), .cal_mode_i(cal_mode),
      .feedback_layout_select_i(fb_sel), .output_enable_i(out_en), .channel_active_i(active),
      .dither_enable_i(dither), .sample_valid_i(valid), .sample_i(sample), .cycle_end_i(cyc_end),
      .dither_end_i(dth_end), .offset_cal_launch_o(launch), .offset_cal_done_i(done),
      .offset_cal_value_i(offset));

   link_master_model i_link_master_model (
      .link_clk_o(link_clk), .frame_sel_n_o(frame_sel_n), .tx_data_o(mosi), .rx_data_i(miso));

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t reply %h expected %h", $time, got, exp);
      end
   endtask : chk32

   task automatic chk_n(input int got, input int exp);
      tests_run++;
      if (got != exp) begin
         error_cnt++;
         $display("BAD %0t launch count %0d expected %0d", $time, got, exp);
      end
   endtask : chk_n

   // A frame is answered during the next one, so an unknown-code frame fetches it.
   task automatic xact(input logic [31:0] tx, input logic [31:0] exp);
      logic [31:0] rx;
      i_link_master_model.xfer(tx, rx);
      i_link_master_model.xfer(32'h0000_0000, rx);
      chk32(rx, exp);
      @(posedge clock_i);
   endtask : xact

   // Kinds: 0 sample, 1 cycle end, 2 dither end, 3 calibration done.
   task automatic pulse(input int ch, input int k, input logic [15:0] v);
      @(posedge clock_i);
      case (k)
         0: begin
            valid[ch] <= 1'h1;
            sample[ch] <= v;
         end
         1: cyc_end[ch] <= 1'h1;
         2: dth_end[ch] <= 1'h1;
         default: begin
            done[ch] <= 1'h1;
            offset[ch] <= v[OFFSET_W-1:0];
         end
      endcase
      @(posedge clock_i);
      valid <= 2'h0;
      cyc_end <= 2'h0;
      dth_end <= 2'h0;
      done <= 2'h0;
   endtask : pulse

   task automatic t_reset;
      xact(32'h0000_0000, 32'h0000_0000);
      xact(32'h3980_0000, 32'h3980_0000);
      xact(32'h4100_0000, 32'h4100_0000);
   endtask : t_reset

   task automatic t_launch;
      xact(32'hB980_0000, 32'h3980_0000);
      chk_n(nl[0], 1);
      xact(32'hBA80_0000, 32'h3A80_0000);
      chk_n(nl[1], 0);
      xact(32'hB900_0000, 32'h3900_0000);
      chk_n(nl[0], 1);
      pulse(0, 3, 16'h0A5C);
      xact(32'h3D00_0000, 32'h3900_0A5C);
      xact(32'h3A00_0000, 32'h3A00_0000);
      xact(32'h3B80_0000, 32'h3B00_0000);
   endtask : t_launch

   task automatic t_cal;
      cal_mode <= 1'h1;
      pulse(0, 0, 16'h1234);
      xact(32'hC100_0000, 32'h4112_3400);
      cal_mode <= 1'h0;
   endtask : t_cal

   task automatic t_sum;
      active <= 2'h2;
      pulse(1, 1, 16'h0000);
      pulse(1, 0, 16'h1000);
      pulse(1, 0, 16'h2000);
      repeat (154) @(posedge clock_i);
      pulse(1, 1, 16'h0000);
      xact(32'h4200_0000, 32'h4203_000A);
      xact(32'h4200_0000, 32'h4200_000A);
      active <= 2'h0;
      xact(32'h4200_0000, 32'h4200_0000);
   endtask : t_sum

   task automatic t_ext;
      fb_sel <= 1'h1;
      active <= 2'h1;
      pulse(0, 0, 16'h4000);
      pulse(0, 0, 16'h2500);
      pulse(0, 0, 16'h6000);
      pulse(0, 1, 16'h0000);
      xact(32'h4100_0000, 32'h4160_2500);
      xact(32'h4100_0000, 32'h4100_FF00);
   endtask : t_ext

   task automatic t_dither;
      active <= 2'h2;
      dither <= 2'h2;
      pulse(1, 2, 16'h0000);
      pulse(1, 0, 16'h3000);
      pulse(1, 0, 16'h5000);
      repeat (3) pulse(1, 1, 16'h0000);
      pulse(1, 2, 16'h0000);
      xact(32'h4200_0000, 32'h4250_3003);
      active <= 2'h0;
      xact(32'h4200_0000, 32'h4200_0000);
   endtask : t_dither

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   initial begin
      #1000000;
      error_cnt++;
      $display("BAD %0t watchdog expired", $time);
      conclude();
   end

   initial begin
      repeat (12) @(posedge clock_i);
      resetn_i <= 1'h1;
      repeat (3) @(posedge clock_i);
      t_reset();
      t_launch();
      t_cal();
      t_sum();
      t_ext();
      t_dither();
      conclude();
   end
endmodule : test_autozero_feedback_regs

`default_nettype wire
